// file: bst_jtag_ctl.sv
// external test controller model driving the test clock, mode select and serial in
// assumes core_clk is the bench clock; test clock edges fall on its falling edges
`default_nettype none

module bst_jtag_ctl
(
   input wire logic core_clk,
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // ------------------------------------------------------------
   // one test clock period: 4 core cycles low, 4 high (320 ns)
   // ------------------------------------------------------------
   // mode select and serial in set up 3 core cycles before the rise
   // serial out sampled late in the high phase, where it still holds the bit
   // shifted out at this rise
   task automatic tick(input logic m, input logic d, output logic so, output logic soe);
      @(negedge core_clk);
      tms = m;
      tdi = d;
      repeat (3) @(negedge core_clk);
      tck = 1'b1;
      repeat (3) @(negedge core_clk);
      so = tdo;
      soe = tdo_oe_n;
      @(negedge core_clk);
      tck = 1'b0;
   endtask : tick

   // move the controller; serial in is not looked at, so it toggles
   task automatic nav(input logic m);
      logic so;
      logic soe;
      tick(m, ~tdi, so, soe);
   endtask : nav

   // five rises with mode select high force test-logic-reset
   task automatic reset5();
      repeat (5) nav(1'b1);
   endtask : reset5

endmodule : bst_jtag_ctl

`default_nettype wire

// file: bst_pkg.sv
// boundary-scan test port: shared constants, states and instruction codes
// assumes a single core clock domain; the test clock is sampled as data
//
// Operation
// - four test pins: test clock, mode select, serial in, serial out
// - controller state held in a four-bit state machine
// - transitions follow mode select sampled at each test clock rising edge
// - power-up reset puts the controller in test-logic-reset
// - five test clock cycles with mode select high reach test-logic-reset
// - extest, sample/preload and bypass supported, plus optional idcode
// - three data registers: bypass, identification, boundary-scan
// - bypass register selected whenever no other data register is needed
// - identification register is 32 bits in four fields
// - boundary-scan cells capture and drive every pin's state
// - each state routes shifting to instruction or selected data register
`default_nettype none

package bst_pkg;

   // ------------------------------------------------------------
   // controller states
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      BST_TLR    = 4'b1111,
      BST_RTI    = 4'b1100,
      BST_SEL_DR = 4'b0111,
      BST_CAP_DR = 4'b0110,
      BST_SH_DR  = 4'b0010,
      BST_EX1_DR = 4'b0001,
      BST_PA_DR  = 4'b0011,
      BST_EX2_DR = 4'b0000,
      BST_UP_DR  = 4'b0101,
      BST_SEL_IR = 4'b0100,
      BST_CAP_IR = 4'b1110,
      BST_SH_IR  = 4'b1010,
      BST_EX1_IR = 4'b1001,
      BST_PA_IR  = 4'b1011,
      BST_EX2_IR = 4'b1000,
      BST_UP_IR  = 4'b1101
   } bst_state_t;

   // ------------------------------------------------------------
   // instruction register
   // ------------------------------------------------------------
   localparam int BST_IR_W = 3;
   localparam logic [2:0] BST_INS_EXTEST = 3'h0;
   localparam logic [2:0] BST_INS_SAMPLE = 3'h1;
   localparam logic [2:0] BST_INS_IDCODE = 3'h2;
   localparam logic [2:0] BST_INS_BYPASS = 3'h7;
   localparam logic [2:0] BST_IR_CAPTURE = 3'h1;
   localparam logic [2:0] BST_IR_RESET = BST_INS_IDCODE;

   // ------------------------------------------------------------
   // identification register fields (values arbitrary)
   // ------------------------------------------------------------
   localparam int BST_ID_W = 32;
   localparam logic [3:0] BST_ID_VERSION = 4'h1;
   localparam logic [15:0] BST_ID_PART = 16'h0A5C;
   localparam logic [3:0] BST_ID_NUMBER = 4'h3;
   localparam logic [7:0] BST_ID_LSB = 8'h01;
   localparam logic [31:0] BST_IDCODE =
      {BST_ID_VERSION, BST_ID_PART, BST_ID_NUMBER, BST_ID_LSB};

   // ------------------------------------------------------------
   // pins and sampling
   // ------------------------------------------------------------
   localparam int BST_PINS = 8;
   localparam int BST_BSR_W = 2 * BST_PINS;
   localparam int BST_SYNC_W = 3 + BST_PINS;
   localparam int BST_SYN_TCK = 0;
   localparam int BST_SYN_TMS = 1;
   localparam int BST_SYN_TDI = 2;
   localparam int BST_SYN_PAD = 3;
   localparam int BST_RESET_STEPS = 5;

endpackage : bst_pkg

`default_nettype wire

// file: bst_tap_fsm.sv
// boundary-scan controller state machine
// assumes step is a one-cycle pulse per recognised test clock rising edge
`default_nettype none

module bst_tap_fsm
   import bst_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic step,
   input wire logic tms,
   output bst_state_t state
);

   bst_state_t next_state;
   logic [2:0] high_run;

   always_comb
   begin
      case (state)
         BST_TLR:    next_state = tms ? BST_TLR : BST_RTI;
         BST_RTI:    next_state = tms ? BST_SEL_DR : BST_RTI;
         BST_SEL_DR: next_state = tms ? BST_SEL_IR : BST_CAP_DR;
         BST_CAP_DR: next_state = tms ? BST_EX1_DR : BST_SH_DR;
         BST_SH_DR:  next_state = tms ? BST_EX1_DR : BST_SH_DR;
         BST_EX1_DR: next_state = tms ? BST_UP_DR : BST_PA_DR;
         BST_PA_DR:  next_state = tms ? BST_EX2_DR : BST_PA_DR;
         BST_EX2_DR: next_state = tms ? BST_UP_DR : BST_SH_DR;
         BST_UP_DR:  next_state = tms ? BST_SEL_DR : BST_RTI;
         BST_SEL_IR: next_state = tms ? BST_TLR : BST_CAP_IR;
         BST_CAP_IR: next_state = tms ? BST_EX1_IR : BST_SH_IR;
         BST_SH_IR:  next_state = tms ? BST_EX1_IR : BST_SH_IR;
         BST_EX1_IR: next_state = tms ? BST_UP_IR : BST_PA_IR;
         BST_PA_IR:  next_state = tms ? BST_EX2_IR : BST_PA_IR;
         BST_EX2_IR: next_state = tms ? BST_UP_IR : BST_SH_IR;
         BST_UP_IR:  next_state = tms ? BST_SEL_DR : BST_RTI;
         default:    next_state = BST_TLR;
      endcase
   end

   // outside reset, state moves only on a test clock rising edge
   always_ff @(posedge core_clk)
   begin
      if (rst)
         state <= BST_TLR;
      else if (step)
         state <= next_state;
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   // counts consecutive rising edges with mode select high
   always_ff @(posedge core_clk)
   begin
      if (rst)
         high_run <= 3'h0;
      else if (step)
         high_run <= !tms ? 3'h0 : (high_run == 3'h7 ? high_run : high_run + 3'h1);
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   chk_five_high_reset: assert property (
      step && tms && high_run == 3'(BST_RESET_STEPS - 1) |=> state == BST_TLR)
      else $error("five high mode select steps did not reach reset state");

   chk_state_holds_idle: assert property (
      !step |=> $stable(state))
      else $error("state moved without a test clock edge");

   chk_leave_reset: assert property (
      step && !tms && state == BST_TLR |=> state == BST_RTI)
      else $error("reset state not left on low mode select");

   chk_powerup_reset: assert property (@(posedge core_clk) disable iff (1'b0)
      rst |=> state == BST_TLR)
      else $error("reset did not place controller in reset state");

endmodule : bst_tap_fsm

`default_nettype wire

// file: bst_test_port.sv
// boundary-scan test access port with instruction and data registers
// assumes tck, tms, tdi and pad inputs are asynchronous to core_clk;
// tck must stay low and high at least three core clock periods each
`default_nettype none

module bst_test_port
   import bst_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe_n,
   input wire logic [BST_PINS-1:0] core_out,
   input wire logic [BST_PINS-1:0] core_oe,
   output logic [BST_PINS-1:0] core_in,
   input wire logic [BST_PINS-1:0] pad_in,
   output logic [BST_PINS-1:0] pad_out,
   output logic [BST_PINS-1:0] pad_oe
);

   // ------------------------------------------------------------
   // pin sampling and test clock edges
   // ------------------------------------------------------------
   logic [BST_SYNC_W-1:0] sync1;
   logic [BST_SYNC_W-1:0] sync2;
   logic [BST_SYNC_W-1:0] sync3;
   logic [BST_SYNC_W-1:0] filt;
   logic [BST_SYNC_W-1:0] next_filt;
   logic tck_prev;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end
      else
      begin
         sync1 <= {pad_in, tdi, tms, tck};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // a level is accepted once the second and third stages agree
   genvar gi;
   generate
      for (gi = 0; gi < BST_SYNC_W; gi = gi + 1)
      begin : g_filt
         assign next_filt[gi] = (sync2[gi] == sync3[gi]) ? sync3[gi] : filt[gi];
      end
   endgenerate

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         filt <= '0;
         tck_prev <= 1'b0;
      end
      else
      begin
         filt <= next_filt;
         tck_prev <= filt[BST_SYN_TCK];
      end
   end

   wire tck_rise = filt[BST_SYN_TCK] & ~tck_prev;
   wire tck_fall = ~filt[BST_SYN_TCK] & tck_prev;
   wire tms_s = filt[BST_SYN_TMS];
   wire tdi_s = filt[BST_SYN_TDI];
   wire [BST_PINS-1:0] pad_s = filt[BST_SYNC_W-1:BST_SYN_PAD];

   // ------------------------------------------------------------
   // controller
   // ------------------------------------------------------------
   bst_state_t state;

   bst_tap_fsm u_fsm (
      .core_clk (core_clk),
      .rst      (rst),
      .step     (tck_rise),
      .tms      (tms_s),
      .state    (state)
   );

   // ------------------------------------------------------------
   // instruction decode and data register selection
   // ------------------------------------------------------------
   logic [BST_IR_W-1:0] ir;
   logic [BST_IR_W-1:0] ir_sh;
   logic byp;
   logic [BST_ID_W-1:0] id_sh;
   logic [BST_BSR_W-1:0] bsr_sh;
   logic [BST_BSR_W-1:0] bsr_upd;
   logic [BST_BSR_W-1:0] bsr_cap;

   wire sel_extest = (ir == BST_INS_EXTEST);
   wire sel_sample = (ir == BST_INS_SAMPLE);
   wire sel_id = (ir == BST_INS_IDCODE);
   wire sel_bsr = sel_extest | sel_sample;
   wire sel_byp = ~(sel_bsr | sel_id);
   wire in_sh_ir = (state == BST_SH_IR);
   wire in_sh_dr = (state == BST_SH_DR);
   wire dr_out = sel_bsr ? bsr_sh[0] : (sel_id ? id_sh[0] : byp);
   wire ser_out = in_sh_ir ? ir_sh[0] : dr_out;

   // per pin: even cell holds pad data, odd cell holds output enable
   generate
      for (gi = 0; gi < BST_PINS; gi = gi + 1)
      begin : g_cell
         assign bsr_cap[2*gi] = pad_s[gi];
         assign bsr_cap[2*gi+1] = core_oe[gi];
      end
   endgenerate

   // ------------------------------------------------------------
   // instruction register
   // ------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
         ir_sh <= BST_IR_CAPTURE;
      else if (tck_rise && state == BST_CAP_IR)
         ir_sh <= BST_IR_CAPTURE;
      else if (tck_rise && in_sh_ir)
         ir_sh <= {tdi_s, ir_sh[BST_IR_W-1:1]};
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         ir <= BST_IR_RESET;
      else if (state == BST_TLR)
         ir <= BST_IR_RESET;
      else if (tck_fall && state == BST_UP_IR)
         ir <= ir_sh;
   end

   // ------------------------------------------------------------
   // data registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         byp <= 1'b0;
         id_sh <= BST_IDCODE;
         bsr_sh <= '0;
      end
      else if (tck_rise && state == BST_CAP_DR)
      begin
         byp <= 1'b0;
         id_sh <= BST_IDCODE;
         if (sel_bsr)
            bsr_sh <= bsr_cap;
      end
      else if (tck_rise && in_sh_dr)
      begin
         if (sel_byp)
            byp <= tdi_s;
         if (sel_id)
            id_sh <= {tdi_s, id_sh[BST_ID_W-1:1]};
         if (sel_bsr)
            bsr_sh <= {tdi_s, bsr_sh[BST_BSR_W-1:1]};
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         bsr_upd <= '0;
      else if (tck_fall && state == BST_UP_DR && sel_bsr)
         bsr_upd <= bsr_sh;
   end

   // ------------------------------------------------------------
   // serial out and pins
   // ------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         tdo <= 1'b0;
         tdo_oe_n <= 1'b1;
      end
      else if (tck_fall)
      begin
         tdo <= ser_out;
         tdo_oe_n <= ~(in_sh_ir | in_sh_dr);
      end
   end

   wire [BST_PINS-1:0] upd_data;
   wire [BST_PINS-1:0] upd_oe;
   generate
      for (gi = 0; gi < BST_PINS; gi = gi + 1)
      begin : g_upd
         assign upd_data[gi] = bsr_upd[2*gi];
         assign upd_oe[gi] = bsr_upd[2*gi+1];
      end
   endgenerate

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         pad_out <= '0;
         pad_oe <= '0;
         core_in <= '0;
      end
      else
      begin
         pad_out <= sel_extest ? upd_data : core_out;
         pad_oe <= sel_extest ? upd_oe : core_oe;
         core_in <= pad_s;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence fall_in_update_ir;
      tck_fall && state == BST_UP_IR;
   endsequence

   sequence rise_in_capture_dr;
      tck_rise && state == BST_CAP_DR;
   endsequence

   chk_tdo_on_fall: assert property (
      !tck_fall |=> $stable(tdo) && $stable(tdo_oe_n))
      else $error("serial out changed away from a falling edge");

   chk_tdo_drive_shift: assert property (
      $fell(tdo_oe_n) |-> $past(in_sh_ir || in_sh_dr))
      else $error("serial out enabled outside a shift state");

   chk_ir_update: assert property (
      fall_in_update_ir |=> ir == $past(ir_sh))
      else $error("instruction not updated from shift stage");

   chk_tlr_ir_reset: assert property (
      state == BST_TLR |=> ir == BST_IR_RESET)
      else $error("instruction not reset in reset state");

   chk_bypass_capture: assert property (
      rise_in_capture_dr |=> byp == 1'b0)
      else $error("bypass did not capture zero");

   chk_id_capture: assert property (
      rise_in_capture_dr |=> id_sh == BST_IDCODE)
      else $error("identification value not captured");

   chk_bsr_capture: assert property (
      rise_in_capture_dr ##0 sel_bsr |=> bsr_sh == $past(bsr_cap))
      else $error("boundary cells did not capture pins");

   chk_extest_drive: assert property (
      sel_extest ##1 sel_extest |-> pad_out == $past(upd_data) && pad_oe == $past(upd_oe))
      else $error("pins not driven from update cells in extest");

   chk_dr_shift_route: assert property (
      tck_fall && in_sh_dr |=> tdo == $past(dr_out) && !tdo_oe_n)
      else $error("data shift not routed to serial out");

endmodule : bst_test_port

`default_nettype wire

// file: tb_top.sv
// self-checking bench for the boundary-scan test port
// assumes the controller model bst_jtag_ctl sits on the test pins
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import bst_pkg::*;

   logic core_clk;
   logic rst;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdo_oe_n;
   logic [BST_PINS-1:0] core_out;
   logic [BST_PINS-1:0] core_oe;
   logic [BST_PINS-1:0] core_in;
   logic [BST_PINS-1:0] pad_in;
   logic [BST_PINS-1:0] pad_out;
   logic [BST_PINS-1:0] pad_oe;
   int errors;
   int comparisons;
   logic [15:0] preload;

   bst_test_port u_bst_test_port (
      .core_clk(core_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .tdo_oe_n(tdo_oe_n), .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));

   bst_jtag_ctl u_bst_jtag_ctl (
      .core_clk(core_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .tdo_oe_n(tdo_oe_n));

   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic test_done();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   // full scan from run-test/idle back to run-test/idle, lsb first
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic so;
      logic soe;
      logic oe_hi;
      dout = '0;
      oe_hi = 1'b0;
      u_bst_jtag_ctl.nav(1'b1);
      if (ir)
         u_bst_jtag_ctl.nav(1'b1);
      u_bst_jtag_ctl.nav(1'b0);
      u_bst_jtag_ctl.nav(1'b0);
      for (int i = 0; i < n; i++)
      begin
         u_bst_jtag_ctl.tick(i == n - 1, din[i], so, soe);
         dout[i] = so;
         oe_hi = oe_hi | soe;
      end
      check("tdo enable while shifting", 32'(oe_hi), 32'h0);
      u_bst_jtag_ctl.nav(1'b1);
      u_bst_jtag_ctl.nav(1'b0);
      check("tdo enable after shift", 32'(tdo_oe_n), 32'h1);
   endtask : scan

   task automatic load_ir(input logic [2:0] code);
      logic [31:0] o;
      scan(1'b1, BST_IR_W, 32'(code), o);
      check("ir capture", o, 32'(BST_IR_CAPTURE));
   endtask : load_ir

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic test_reset();
      logic [31:0] o;
      check("tdo enable at reset", 32'(tdo_oe_n), 32'h1);
      check("pads at reset", {16'h0, pad_out, pad_oe}, 32'h0);
      u_bst_jtag_ctl.nav(1'b0);
      scan(1'b0, BST_ID_W, 32'h0, o);
      check("idcode after reset", o, BST_IDCODE);
      $display("test reset done");
   endtask : test_reset

   task automatic test_bypass();
      logic [2:0] codes [2];
      logic [31:0] o;
      codes[0] = BST_INS_BYPASS;
      codes[1] = 3'h5;
      foreach (codes[k])
      begin
         load_ir(codes[k]);
         scan(1'b0, 8, 32'hA5, o);
         check("bypass path", o, 32'h4A);
      end
      $display("test bypass done");
   endtask : test_bypass

   task automatic test_sample(input logic [7:0] pi,
                              input logic [7:0] co,
                              input logic [7:0] coe);
      logic [31:0] o;
      logic [15:0] exp;
      @(negedge core_clk);
      pad_in = pi;
      core_oe = coe;
      core_out = co;
      repeat (8) @(negedge core_clk);
      check("pads normal", {8'h0, core_in, pad_out, pad_oe}, {8'h0, pi, co, coe});
      for (int i = 0; i < BST_PINS; i++)
      begin
         exp[2*i] = pad_in[i];
         exp[2*i+1] = core_oe[i];
      end
      load_ir(BST_INS_SAMPLE);
      scan(1'b0, BST_BSR_W, 32'(preload), o);
      check("boundary capture", o, 32'(exp));
      check("pads under sample", {16'h0, pad_out, pad_oe}, {16'h0, co, coe});
      $display("test sample done");
   endtask : test_sample

   task automatic test_extest();
      logic [7:0] ed;
      logic [7:0] ee;
      for (int i = 0; i < BST_PINS; i++)
      begin
         ed[i] = preload[2*i];
         ee[i] = preload[2*i+1];
      end
      load_ir(BST_INS_EXTEST);
      check("pads under extest", {16'h0, pad_out, pad_oe}, {16'h0, ed, ee});
      $display("test extest done");
   endtask : test_extest

   task automatic test_force_reset();
      logic [31:0] o;
      u_bst_jtag_ctl.nav(1'b1);
      u_bst_jtag_ctl.nav(1'b0);
      u_bst_jtag_ctl.nav(1'b0);
      u_bst_jtag_ctl.nav(1'b0);
      u_bst_jtag_ctl.reset5();
      repeat (8) @(negedge core_clk);
      check("pads after forced reset", {16'h0, pad_out, pad_oe}, 32'hC30F);
      u_bst_jtag_ctl.nav(1'b0);
      scan(1'b0, BST_ID_W, 32'h0, o);
      check("idcode after forced reset", o, BST_IDCODE);
      $display("test force reset done");
   endtask : test_force_reset

   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      errors = 0;
      comparisons = 0;
      preload = 16'h9A65;
      rst = 1'b1;
      pad_in = '0;
      core_out = '0;
      core_oe = '0;
      repeat (2) @(negedge core_clk);
      rst = 1'b0;
      repeat (4) @(negedge core_clk);
      test_reset();
      test_bypass();
      test_sample(8'hA7, 8'h3C, 8'hF0);
      test_sample(8'h5A, 8'hC3, 8'h0F);
      test_extest();
      test_force_reset();
      test_done();
   end

   // the whole run needs about 1600 core cycles
   initial
   begin
      #400000;
      errors++;
      test_done();
   end

endmodule : tb_top

`default_nettype wire
